// *** design/lms_pkg.sv ***
// Package with constants, frame types, primitive codes and carriers for the link setup engine.
package lms_pkg;
  localparam int LMS_SEQ_W = 7;
  localparam int LMS_CNT_W = 16;
  localparam int LMS_RETRY_W = 8;
  localparam logic [3:0] LMS_WB_ADR_CTRL   = 4'h0;
  localparam logic [3:0] LMS_WB_ADR_T200   = 4'h1;
  localparam logic [3:0] LMS_WB_ADR_T203   = 4'h2;
  localparam logic [3:0] LMS_WB_ADR_N200   = 4'h3;
  localparam logic [3:0] LMS_WB_ADR_STATUS = 4'h4;
  localparam logic [3:0] LMS_WB_ADR_TICK   = 4'h5;
  localparam int LMS_CTRL_T203_EN_BIT = 0;
  localparam int LMS_CTRL_ABLE_BIT    = 1;
  localparam logic [15:0] LMS_T200_RST = 16'h0064;
  localparam logic [15:0] LMS_T203_RST = 16'h03e8;
  localparam logic [7:0]  LMS_N200_RST = 8'h03;
  localparam logic [15:0] LMS_TICK_RST = 16'h0063;
  localparam logic [1:0]  LMS_CTRL_RST = 2'h3;
  localparam logic [31:0] LMS_WB_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    LMS_FR_NONE, LMS_FR_SABME, LMS_FR_DISC, LMS_FR_UA, LMS_FR_DM, LMS_FR_OTHER_U, LMS_FR_NON_U
  } lms_frame_t;

  typedef enum logic [1:0] {
    LMS_ST_TEI_ASSIGNED, LMS_ST_AWAIT_EST, LMS_ST_ESTABLISHED, LMS_ST_AWAIT_REL
  } lms_state_t;

  typedef struct packed {
    logic       valid;
    lms_frame_t kind;
    logic       pf;
  } lms_frame_s_t;

  typedef struct packed {
    logic est_ind;
    logic est_cnf;
    logic rel_ind;
    logic rel_cnf;
    logic mdl_err;
    logic mdl_dup_tei;
    logic discard_q;
  } lms_prim_t;
endpackage : lms_pkg

// *** design/lms_tick.sv ***
// Tick divider that makes the one-cycle timer enable.
`timescale 1ns/1ns
`default_nettype none
module lms_tick
  import lms_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic [LMS_CNT_W-1:0] div_val,
  output logic                      tick
);
  logic [LMS_CNT_W-1:0] cnt_ff;
  wire                  wrap = (cnt_ff >= div_val);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      tick   <= 1'b0;
    end else begin
      cnt_ff <= wrap ? '0 : cnt_ff + 1'b1;
      tick   <= wrap;
    end
  end
endmodule : lms_tick
`default_nettype wire

// *** design/lms_timer.sv ***
// Down counter timer measured in ticks, with start, stop and a one-cycle expiry pulse.
`timescale 1ns/1ns
`default_nettype none
module lms_timer
  import lms_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 tick,
  input  wire logic                 start,
  input  wire logic                 stop,
  input  wire logic [LMS_CNT_W-1:0] period,
  output logic                      running,
  output logic                      expired
);
  logic [LMS_CNT_W-1:0] cnt_ff;
  wire                  last = running && tick && (cnt_ff <= 16'h0001);

  // Start beats stop so that a restart in the expiry cycle is kept.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= last && !start && !stop;
      if (start) begin
        cnt_ff  <= (period == '0) ? 16'h0001 : period;
        running <= 1'b1;
      end else if (stop || last) begin
        running <= 1'b0;
      end else if (running && tick) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule : lms_timer
`default_nettype wire

// *** design/lms_link_setup.sv ***
// Setup and release state machine of an acknowledged-mode link entity, with a Wishbone slave.
// How it works
// [R1] Establish: send SABME, clear exceptions, zero retry count, start T200.
// [R2] SABME and DISC always go out with poll set.
// [R3] Layer 3 establishment discards pending data requests and queued I frames.
// [R4] Accepted SABME: UA with F=P, zero sequence, established, indicate, start T203.
// [R5] Refused SABME: DM with F equal to received P.
// [R6] UA F=1 while establishing: stop T200, start T203, zero sequence, confirm.
// [R7] DM F=1 while establishing: release indication, stop T200, TEI assigned; F=0 ignored.
// [R8] Non-unnumbered frames are ignored while establishing.
// [R9] Release request during link re-establishment waits for the exchange to finish.
// [R10] T200 expiry while establishing: resend SABME, restart T200, count retry.
// [R11] N200 SABME retries: release indication, error, discard queues, TEI assigned.
// [R12] SABME while established runs re-establishment instead of plain setup answer.
// [R13] Releasing ignores non-unnumbered frames and discards data requests and I frames.
// [R14] Persistent deactivation: discard queues; confirm if awaiting release, else indication.
// [R15] Release request: send DISC with poll set, start T200, zero retry count.
// [R16] DISC when established: UA with F=P, release indication, TEI assigned.
// [R17] UA or DM F=1 while releasing: TEI assigned, stop T200, release confirm.
// [R18] T200 expiry while releasing: resend DISC, restart T200, count retry.
// [R19] N200 DISC retries: error indication, TEI assigned, release confirm.
// [R20] DISC in TEI assigned: answer DM with F equal to received P.
// [R21] DM F=0 in TEI assigned starts establishment if able, else ignored.
// [R22] UA in TEI assigned raises duplicate TEI error; other frames discarded.
// [R23] T200, T203 and N200 are programmable; timers count tick enables.
// [R24] V(S), V(R) and V(A) are seven bits wide.
`timescale 1ns/1ns
`default_nettype none
module lms_link_setup
  import lms_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 l3_est_req,
  input  wire logic                 l3_rel_req,
  input  wire logic                 link_reest_req,
  input  wire logic                 ph_deact_ind,
  input  wire lms_frame_s_t         rx_frame,
  output lms_frame_s_t              tx_frame,
  output lms_prim_t                 prim,
  output lms_state_t                state,
  output logic [LMS_SEQ_W-1:0]      vs,
  output logic [LMS_SEQ_W-1:0]      vr,
  output logic [LMS_SEQ_W-1:0]      va,
  output logic                      t203_running,
  output logic                      t203_expired,
  output logic                      reest_start
);
  logic [15:0]            t200_ff;
  logic [15:0]            t203_ff;
  logic [7:0]             n200_ff;
  logic [15:0]            tick_div_ff;
  logic [1:0]             ctrl_ff;
  logic [LMS_RETRY_W-1:0] retry_ff;
  logic                   link_reest_ff;
  logic                   rel_pend_ff;
  logic                   l3_rel_out_ff;
  logic                   peer_busy_ff;
  logic                   exc_ff;
  logic                   tick;
  logic                   t200_running;
  logic                   t200_expired;

  function automatic logic f_is(input lms_frame_s_t f, input lms_frame_t k);
    return f.valid && (f.kind == k);
  endfunction : f_is

  wire t203_en  = ctrl_ff[LMS_CTRL_T203_EN_BIT];
  wire can_est  = ctrl_ff[LMS_CTRL_ABLE_BIT];
  wire rx_sabme = f_is(rx_frame, LMS_FR_SABME);
  wire rx_disc  = f_is(rx_frame, LMS_FR_DISC);
  wire rx_ua_f1 = f_is(rx_frame, LMS_FR_UA) && rx_frame.pf;
  wire rx_ua    = f_is(rx_frame, LMS_FR_UA);
  wire rx_dm_f1 = f_is(rx_frame, LMS_FR_DM) && rx_frame.pf;
  wire rx_dm_f0 = f_is(rx_frame, LMS_FR_DM) && !rx_frame.pf;
  wire retry_out = (retry_ff >= n200_ff);

  wire in_tei = (state == LMS_ST_TEI_ASSIGNED);
  wire in_est = (state == LMS_ST_AWAIT_EST);
  wire in_mfe = (state == LMS_ST_ESTABLISHED);
  wire in_rel = (state == LMS_ST_AWAIT_REL);

  // Frame events are decoded ahead of the primitive requests; a frame event in any_rx blocks the layer 3 requests in its cycle.
  wire ev_deact    = ph_deact_ind && !in_tei; // R14
  wire ev_sabme_ok = rx_sabme && can_est && (in_tei || in_est); // R4
  wire ev_sabme_no = rx_sabme && !can_est && !in_mfe; // R5
  wire ev_reest    = (rx_sabme && in_mfe) || (link_reest_req && in_mfe); // R12
  wire ev_est_ua   = in_est && rx_ua_f1; // R6
  wire ev_est_dm   = in_est && rx_dm_f1; // R7 R8
  wire ev_est_exp  = in_est && t200_expired && !ev_est_ua && !ev_est_dm && !ev_sabme_ok;
  wire ev_est_fail = ev_est_exp && retry_out; // R11
  wire ev_rel_done = in_rel && (rx_ua_f1 || rx_dm_f1); // R17 R13
  wire ev_rel_exp  = in_rel && t200_expired && !ev_rel_done;
  wire ev_rel_fail = ev_rel_exp && retry_out; // R19
  wire ev_disc_mfe = in_mfe && rx_disc; // R16
  wire ev_disc_tei = in_tei && rx_disc; // R20
  wire ev_dm_tei   = in_tei && rx_dm_f0 && can_est; // R21
  wire ev_ua_tei   = in_tei && rx_ua; // R22
  wire any_rx      = ev_sabme_ok | ev_sabme_no | ev_est_ua | ev_est_dm | ev_rel_done
                   | ev_disc_mfe | ev_disc_tei;
  wire ev_l3_est   = l3_est_req && (in_tei || in_mfe) && !any_rx && !ev_deact;
  wire rel_go      = (l3_rel_req || (rel_pend_ff && !link_reest_ff)) && in_mfe;
  wire ev_l3_rel   = rel_go && !any_rx && !ev_deact && !ev_reest;
  wire hold_rel    = l3_rel_req && in_est && link_reest_ff; // R9
  wire start_est   = ev_l3_est || ev_dm_tei || ev_reest; // R1
  wire send_sabme  = start_est || (ev_est_exp && !retry_out); // R10
  wire send_disc   = ev_l3_rel || (ev_rel_exp && !retry_out); // R15 R18
  wire zero_seq    = ev_sabme_ok || ev_est_ua; // R4 R6

  lms_state_t nxt_state;
  always_comb begin
    nxt_state = state;
    if (ev_deact || ev_est_dm || ev_est_fail || ev_rel_done || ev_rel_fail || ev_disc_mfe) begin
      nxt_state = LMS_ST_TEI_ASSIGNED;
    end else if (ev_sabme_ok || ev_est_ua) begin
      nxt_state = LMS_ST_ESTABLISHED;
    end else if (start_est) begin
      nxt_state = LMS_ST_AWAIT_EST;
    end else if (ev_l3_rel) begin
      nxt_state = LMS_ST_AWAIT_REL;
    end
  end

  lms_frame_s_t nxt_tx;
  always_comb begin
    nxt_tx = '{valid: 1'b0, kind: LMS_FR_NONE, pf: 1'b0};
    if (ev_deact) begin
      nxt_tx = '{valid: 1'b0, kind: LMS_FR_NONE, pf: 1'b0};
    end else if (ev_sabme_ok || ev_disc_mfe) begin
      nxt_tx = '{valid: 1'b1, kind: LMS_FR_UA, pf: rx_frame.pf}; // R4 R16
    end else if (ev_sabme_no || ev_disc_tei) begin
      nxt_tx = '{valid: 1'b1, kind: LMS_FR_DM, pf: rx_frame.pf}; // R5 R20
    end else if (send_sabme) begin
      nxt_tx = '{valid: 1'b1, kind: LMS_FR_SABME, pf: 1'b1}; // R2
    end else if (send_disc) begin
      nxt_tx = '{valid: 1'b1, kind: LMS_FR_DISC, pf: 1'b1}; // R2
    end
  end

  lms_prim_t nxt_prim;
  always_comb begin
    nxt_prim             = '0;
    nxt_prim.est_ind     = ev_sabme_ok && !ev_deact;
    nxt_prim.est_cnf     = ev_est_ua && !ev_deact;
    nxt_prim.rel_cnf     = (ev_deact && l3_rel_out_ff) || ev_rel_done || ev_rel_fail; // R14 R17
    nxt_prim.rel_ind     = (ev_deact && !l3_rel_out_ff) || ev_est_dm || ev_est_fail
                         || ev_disc_mfe; // R7 R11 R16
    nxt_prim.mdl_err     = ev_est_fail || ev_rel_fail; // R11 R19
    nxt_prim.mdl_dup_tei = ev_ua_tei && !ev_deact; // R22
    nxt_prim.discard_q   = ev_deact || ev_l3_est || ev_est_fail || ev_l3_rel; // R3 R13
  end

  wire t200_start = (send_sabme || send_disc) && !ev_deact;
  wire t200_stop  = ev_est_ua || ev_est_dm || ev_rel_done || ev_deact || ev_est_fail
                  || ev_rel_fail;
  wire t203_start = t203_en && (ev_sabme_ok || ev_est_ua) && !ev_deact;
  wire t203_stop  = (nxt_state != LMS_ST_ESTABLISHED) || !t203_en;

  lms_tick u_tick (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .div_val  (tick_div_ff),
    .tick     (tick)
  );

  lms_timer u_t200 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (tick),
    .start    (t200_start),
    .stop     (t200_stop),
    .period   (t200_ff),
    .running  (t200_running),
    .expired  (t200_expired)
  ); // R23

  logic t203_run_w;
  logic t203_exp_w;
  lms_timer u_t203 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (tick),
    .start    (t203_start),
    .stop     (t203_stop),
    .period   (t203_ff),
    .running  (t203_run_w),
    .expired  (t203_exp_w)
  ); // R23

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= LMS_ST_TEI_ASSIGNED;
      tx_frame     <= '0;
      prim         <= '0;
      reest_start  <= 1'b0;
      t203_running <= 1'b0;
      t203_expired <= 1'b0;
    end else begin
      state        <= nxt_state;
      tx_frame     <= nxt_tx;
      prim         <= nxt_prim;
      reest_start  <= ev_reest && !ev_deact; // R12
      t203_running <= t203_run_w;
      t203_expired <= t203_exp_w;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vs <= '0;
      vr <= '0;
      va <= '0;
    end else if (zero_seq && !ev_deact) begin
      vs <= '0; // R4 R6
      vr <= '0;
      va <= '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      retry_ff      <= '0;
      link_reest_ff <= 1'b0;
      rel_pend_ff   <= 1'b0;
      l3_rel_out_ff <= 1'b0;
      exc_ff        <= 1'b0;
      peer_busy_ff  <= 1'b0;
    end else begin
      if (start_est || ev_l3_rel) begin
        retry_ff <= '0; // R1 R15
      end else if ((ev_est_exp || ev_rel_exp) && !retry_out) begin
        retry_ff <= retry_ff + 1'b1; // R10 R18
      end
      if (start_est) begin
        link_reest_ff <= ev_reest;
      end else if (nxt_state != LMS_ST_AWAIT_EST) begin
        link_reest_ff <= 1'b0;
      end
      if (hold_rel) begin
        rel_pend_ff <= 1'b1; // R9
      end else if (ev_l3_rel || nxt_state == LMS_ST_TEI_ASSIGNED) begin
        rel_pend_ff <= 1'b0;
      end
      if (ev_l3_rel) begin
        l3_rel_out_ff <= 1'b1;
      end else if (nxt_state == LMS_ST_TEI_ASSIGNED) begin
        l3_rel_out_ff <= 1'b0;
      end
      // Exception and peer-busy flags are kept only for status here.
      if (start_est || ev_sabme_ok) begin
        exc_ff       <= 1'b0; // R1 R4
        peer_busy_ff <= 1'b0;
      end
    end
  end

  // Wishbone slave: one wait state, ack pulses for one cycle per request.
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wb_wr  = wb_req && wb_we_i;
  logic [31:0] rd_mux;
  always_comb begin
    case (wb_adr_i)
      LMS_WB_ADR_CTRL:   rd_mux = {30'h0, ctrl_ff};
      LMS_WB_ADR_T200:   rd_mux = {16'h0, t200_ff};
      LMS_WB_ADR_T203:   rd_mux = {16'h0, t203_ff};
      LMS_WB_ADR_N200:   rd_mux = {24'h0, n200_ff};
      LMS_WB_ADR_STATUS: rd_mux = {8'h0, retry_ff, 8'h0, 1'b0, exc_ff, peer_busy_ff,
                                   rel_pend_ff, t200_running, t203_running, state};
      LMS_WB_ADR_TICK:   rd_mux = {16'h0, tick_div_ff};
      default:           rd_mux = LMS_WB_ZERO;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= '0;
      ctrl_ff     <= LMS_CTRL_RST;
      t200_ff     <= LMS_T200_RST;
      t203_ff     <= LMS_T203_RST;
      n200_ff     <= LMS_N200_RST;
      tick_div_ff <= LMS_TICK_RST;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_mux : LMS_WB_ZERO;
      if (wb_wr && wb_sel_i[0]) begin
        case (wb_adr_i)
          LMS_WB_ADR_CTRL: ctrl_ff          <= wb_dat_i[1:0];
          LMS_WB_ADR_T200: t200_ff[7:0]     <= wb_dat_i[7:0]; // R23
          LMS_WB_ADR_T203: t203_ff[7:0]     <= wb_dat_i[7:0];
          LMS_WB_ADR_N200: n200_ff          <= wb_dat_i[7:0];
          LMS_WB_ADR_TICK: tick_div_ff[7:0] <= wb_dat_i[7:0];
          default: ;
        endcase
      end
      if (wb_wr && wb_sel_i[1]) begin
        case (wb_adr_i)
          LMS_WB_ADR_T200: t200_ff[15:8]     <= wb_dat_i[15:8];
          LMS_WB_ADR_T203: t203_ff[15:8]     <= wb_dat_i[15:8];
          LMS_WB_ADR_TICK: tick_div_ff[15:8] <= wb_dat_i[15:8];
          default: ;
        endcase
      end
    end
  end
endmodule : lms_link_setup
`default_nettype wire

// *** tb/lms_link_setup_props.sv ***
// Concurrent checks on the frame and primitive ports of the link setup engine.
`timescale 1ns/1ns
`default_nettype none
module lms_link_setup_props
  import lms_pkg::*;
(
  input wire logic                 core_clk,
  input wire logic                 rst_n,
  input wire logic                 l3_est_req,
  input wire logic                 l3_rel_req,
  input wire logic                 ph_deact_ind,
  input wire lms_frame_s_t         rx_frame,
  input wire lms_frame_s_t         tx_frame,
  input wire lms_prim_t            prim,
  input wire lms_state_t           state,
  input wire logic [LMS_SEQ_W-1:0] vs,
  input wire logic [LMS_SEQ_W-1:0] vr,
  input wire logic [LMS_SEQ_W-1:0] va,
  input wire logic                 t203_running,
  input wire logic                 t203_expired,
  input wire logic                 reest_start
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Outside TEI assigned, deactivation beats any frame, so frame checks leave that cycle out.
  wire rx_ok = rx_frame.valid && !ph_deact_ind;
  wire quiet = !rx_frame.valid && !ph_deact_ind;
  wire seq0  = (vs == '0) && (vr == '0) && (va == '0);
  wire in_tei = state == LMS_ST_TEI_ASSIGNED;
  wire in_est = state == LMS_ST_ESTABLISHED;
  wire in_aw  = state == LMS_ST_AWAIT_EST;
  AST_EST_START: assert property (
    l3_est_req && quiet && in_tei |=> tx_frame.valid && tx_frame.pf
    && tx_frame.kind == LMS_FR_SABME && prim.discard_q && in_aw) else $error("bad establish");
  AST_SABME_ANS: assert property (
    rx_ok && rx_frame.kind == LMS_FR_SABME && in_tei |=> tx_frame.valid
    && tx_frame.pf == $past(rx_frame.pf) && (tx_frame.kind == LMS_FR_UA
    ? prim.est_ind && seq0 && in_est : tx_frame.kind == LMS_FR_DM && in_tei))
    else $error("bad SABME answer");
  AST_UA_CONFIRM: assert property (
    rx_ok && in_aw && rx_frame.kind == LMS_FR_UA && rx_frame.pf |=> seq0
    && prim.est_cnf && in_est) else $error("UA did not establish");
  AST_DM_REFUSED: assert property (
    rx_ok && in_aw && rx_frame.kind == LMS_FR_DM && rx_frame.pf |-> ##1 prim.rel_ind
    && in_tei && !tx_frame.valid) else $error("DM F1 not released");
  AST_IGNORE_AW: assert property (
    rx_ok && in_aw && (rx_frame.kind == LMS_FR_NON_U || rx_frame.kind == LMS_FR_DM
    && !rx_frame.pf) |=> !in_est && !prim.est_cnf) else $error("ignored frame acted on");
  AST_REL_START: assert property (
    l3_rel_req && quiet && in_est |=> tx_frame.valid && tx_frame.kind == LMS_FR_DISC
    && tx_frame.pf && prim.discard_q && state == LMS_ST_AWAIT_REL) else $error("bad release");
  AST_REL_DONE: assert property (
    rx_ok && state == LMS_ST_AWAIT_REL && rx_frame.pf && (rx_frame.kind == LMS_FR_UA
    || rx_frame.kind == LMS_FR_DM) |=> prim.rel_cnf && in_tei) else $error("no release confirm");
  AST_PEER_DISC: assert property (
    rx_ok && in_est && rx_frame.kind == LMS_FR_DISC |=> tx_frame.valid && prim.rel_ind
    && tx_frame.kind == LMS_FR_UA && tx_frame.pf == $past(rx_frame.pf) && in_tei)
    else $error("bad DISC answer");
  AST_TEI_DISC: assert property (
    rx_ok && in_tei && rx_frame.kind == LMS_FR_DISC |=> tx_frame.valid && in_tei
    && tx_frame.kind == LMS_FR_DM && tx_frame.pf == $past(rx_frame.pf)) else $error("bad DM");
  AST_DUP_TEI: assert property (
    rx_ok && in_tei && rx_frame.kind == LMS_FR_UA |=> prim.mdl_dup_tei && in_tei
    && !tx_frame.valid) else $error("no duplicate report");
  AST_REEST: assert property (
    rx_ok && in_est && rx_frame.kind == LMS_FR_SABME |=> reest_start && tx_frame.valid
    && tx_frame.kind == LMS_FR_SABME && in_aw) else $error("no re-establishment");
  AST_DEACT: assert property (
    ph_deact_ind && !in_tei |=> in_tei && prim.discard_q && prim.rel_ind != prim.rel_cnf
    && prim.rel_cnf == ($past(state) == LMS_ST_AWAIT_REL)) else $error("bad deactivation");
  AST_T203_START: assert property ($rose(in_est) |=> t203_running)
    else $error("T203 not started");
  AST_T203_EXP: assert property (t203_expired |-> !t203_running && $past(t203_running))
    else $error("bad T203 expiry");
  COV_EST: cover property (in_aw ##1 in_est);
  COV_ERR: cover property (prim.mdl_err);
  COV_REEST: cover property (reest_start);
endmodule : lms_link_setup_props
bind lms_link_setup lms_link_setup_props u_props (.*);
`default_nettype wire

// *** tb/lms_peer_model.sv ***
// Peer link entity that answers mode-setting commands after a delay, or stays silent.
`timescale 1ns/1ns
`default_nettype none
module lms_peer_model
  import lms_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire lms_frame_s_t tx_frame,
  input  wire lms_frame_s_t inj,
  input  wire logic [1:0]   mode,
  input  wire logic [3:0]   lat,
  output lms_frame_s_t      rx_frame
);
  lms_frame_s_t pend_ff;
  logic [3:0]   wait_ff;
  // Mode 0 accepts with UA, mode 1 refuses with DM, mode 2 never answers.
  wire cmd  = tx_frame.valid && mode != 2'h2
              && (tx_frame.kind == LMS_FR_SABME || tx_frame.kind == LMS_FR_DISC);
  wire fire = pend_ff.valid && wait_ff == 4'h0 && !inj.valid;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_ff  <= '0;
      wait_ff  <= 4'h0;
      rx_frame <= '0;
    end else begin
      // Idle lines invert so a stale frame field is never mistaken for a fresh one.
      rx_frame <= inj.valid ? inj : fire ? pend_ff : {1'b0, ~rx_frame[3:0]};
      wait_ff  <= (wait_ff != 4'h0) ? wait_ff - 4'h1 : 4'h0;
      if (cmd) begin
        pend_ff <= '{1'b1, (mode == 2'h0) ? LMS_FR_UA : LMS_FR_DM, tx_frame.pf};
        wait_ff <= lat;
      end else if (fire) begin
        pend_ff <= '0;
      end
    end
  end
endmodule : lms_peer_model
`default_nettype wire

// *** tb/test_lms_link_setup.sv ***
// Self-checking bench: register access, then setup, retry, release and peer frame cases.
`timescale 1ns/1ns
`default_nettype none
module test_lms_link_setup
  import lms_pkg::*;
;
  logic                 core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic                 l3_est_req, l3_rel_req, link_reest_req, ph_deact_ind;
  logic                 t203_running, t203_expired, reest_start;
  logic [3:0]           wb_adr_i, wb_sel_i, lat, req;
  logic [31:0]          wb_dat_i, wb_dat_o, rd;
  logic [1:0]           mode;
  logic [LMS_SEQ_W-1:0] vs, vr, va;
  lms_frame_s_t         rx_frame, tx_frame, inj;
  lms_prim_t            prim;
  lms_state_t           state;
  int                   errors, check_count, seed, n200, txc[7], pc[7], t0[7], p0[7];
  logic [31:0]          rst_tab[7];
  assign {ph_deact_ind, link_reest_req, l3_rel_req, l3_est_req} = req;
  lms_link_setup u_dut (.*);
  lms_peer_model u_peer (.core_clk(core_clk), .rst_n(rst_n), .tx_frame(tx_frame),
                         .inj(inj), .mode(mode), .lat(lat), .rx_frame(rx_frame));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    stop_test();
  end
  always @(posedge core_clk) begin
    if (tx_frame.valid === 1'b1) txc[tx_frame.kind]++;
    for (int i = 0; i < 7; i++) if (prim[i] === 1'b1) pc[i]++;
  end
  task automatic stop_test();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_n(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_n
  // A command goes out once, then once more for every allowed retry.
  function automatic int sends(input int n);
    return n + 1;
  endfunction : sends
  function automatic int dt(input lms_frame_t k);
    return txc[k] - t0[k];
  endfunction : dt
  function automatic int dp(input int b);
    return pc[b] - p0[b];
  endfunction : dp
  task automatic snap();
    t0 = txc;
    p0 = pc;
  endtask : snap
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      n++;
      @(posedge core_clk);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n == 20) errors++;
  endtask : wb
  task automatic pulse(input logic [3:0] r);
    @(posedge core_clk);
    req <= r;
    @(posedge core_clk);
    req <= 4'h0;
  endtask : pulse
  task automatic send(input lms_frame_t k, input logic p);
    @(posedge core_clk);
    inj <= '{1'b1, k, p};
    @(posedge core_clk);
    inj <= '0;
  endtask : send
  task automatic wait_st(input lms_state_t s);
    int n;
    n = 0;
    while (state !== s && n < 3000) begin
      n++;
      @(posedge core_clk);
    end
    @(posedge core_clk);
    #1;
    chk_reg(32'(state), 32'(s));
  endtask : wait_st
  initial begin
    seed = 16224;
    rst_n = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    {wb_adr_i, wb_sel_i, req, lat} = 16'h0001;
    wb_dat_i = 32'h0;
    inj = '0;
    mode = 2'h0;
    rst_tab = '{32'(LMS_CTRL_RST), 32'(LMS_T200_RST), 32'(LMS_T203_RST),
                32'(LMS_N200_RST), 32'h0, 32'(LMS_TICK_RST), 32'h0};
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    wb(1'b1, 4'h6, 32'hffff_ffff);
    for (int i = 0; i < 7; i++) begin
      wb(1'b0, 4'(i), 32'h0);
      chk_reg(rd, rst_tab[i]);
    end
    n200 = 1 + (($random(seed) & 32'hff) % 3);
    wb(1'b1, LMS_WB_ADR_TICK, 32'h0);
    wb(1'b1, LMS_WB_ADR_T200, 32'h10);
    wb(1'b1, LMS_WB_ADR_T203, 32'h2);
    wb(1'b1, LMS_WB_ADR_N200, 32'(n200));
    wb(1'b0, LMS_WB_ADR_N200, 32'h0);
    chk_reg(rd, 32'(n200));
    lat <= 4'($random(seed) & 3);
    snap();
    pulse(4'h1);
    wait_st(LMS_ST_ESTABLISHED);
    chk_n(dt(LMS_FR_SABME) + dp(5) + dp(0), 3);
    chk_reg(32'({vs, vr, va}), 32'h0);
    snap();
    send(LMS_FR_DISC, 1'b1);
    wait_st(LMS_ST_TEI_ASSIGNED);
    chk_n(dt(LMS_FR_UA) + dp(4), 2);
    mode <= 2'h2;
    snap();
    pulse(4'h1);
    send(LMS_FR_NON_U, 1'($random(seed)));
    send(LMS_FR_DM, 1'b0);
    repeat (2) @(posedge core_clk);
    chk_reg(32'(state), 32'(LMS_ST_AWAIT_EST));
    wait_st(LMS_ST_TEI_ASSIGNED);
    chk_n(dt(LMS_FR_SABME), sends(n200));
    chk_n(dp(4) + dp(2), 2);
    mode <= 2'h0;
    pulse(4'h1);
    wait_st(LMS_ST_ESTABLISHED);
    snap();
    pulse(4'h2);
    wait_st(LMS_ST_TEI_ASSIGNED);
    chk_n(dt(LMS_FR_DISC) + dp(3), 2);
    pulse(4'h1);
    wait_st(LMS_ST_ESTABLISHED);
    lat <= 4'h6;
    snap();
    pulse(4'h4);
    pulse(4'h2);
    chk_reg(32'(state), 32'(LMS_ST_AWAIT_EST));
    wait_st(LMS_ST_TEI_ASSIGNED);
    chk_n(dt(LMS_FR_DISC) + dp(3), 2);
    pulse(4'h1);
    wait_st(LMS_ST_ESTABLISHED);
    mode <= 2'h2;
    snap();
    pulse(4'h2);
    wait_st(LMS_ST_TEI_ASSIGNED);
    chk_n(dt(LMS_FR_DISC), sends(n200));
    chk_n(dp(2) + dp(3), 2);
    snap();
    send(LMS_FR_DISC, 1'b1);
    send(LMS_FR_UA, 1'($random(seed)));
    send(LMS_FR_SABME, 1'b1);
    wait_st(LMS_ST_ESTABLISHED);
    chk_n(dt(LMS_FR_DM) + dt(LMS_FR_UA) + dp(1) + dp(6), 4);
    snap();
    send(LMS_FR_SABME, 1'b1);
    wait_st(LMS_ST_AWAIT_EST);
    chk_n(dt(LMS_FR_SABME), 1);
    mode <= 2'h0;
    wait_st(LMS_ST_ESTABLISHED);
    mode <= 2'h1;
    snap();
    pulse(4'h1);
    wait_st(LMS_ST_TEI_ASSIGNED);
    chk_n(dt(LMS_FR_SABME) + dp(4) + dp(0), 3);
    mode <= 2'h0;
    pulse(4'h1);
    wait_st(LMS_ST_ESTABLISHED);
    mode <= 2'h2;
    snap();
    pulse(4'h2);
    pulse(4'h8);
    wait_st(LMS_ST_TEI_ASSIGNED);
    chk_n(dp(3) + dp(0), 3);
    wb(1'b1, LMS_WB_ADR_CTRL, 32'h1);
    snap();
    send(LMS_FR_SABME, 1'b1);
    send(LMS_FR_DM, 1'b0);
    wb(1'b1, LMS_WB_ADR_CTRL, 32'h3);
    chk_n(dt(LMS_FR_DM) + dt(LMS_FR_SABME), 1);
    send(LMS_FR_DM, 1'b0);
    wait_st(LMS_ST_AWAIT_EST);
    chk_n(dt(LMS_FR_SABME), 1);
    snap();
    pulse(4'h8);
    wait_st(LMS_ST_TEI_ASSIGNED);
    chk_n(dp(4), 1);
    stop_test();
  end
endmodule : test_lms_link_setup
`default_nettype wire
